// ---- core/emm_pkg.sv ----
// Constants for the external data memory address mapper.
// Assumes one system clock; SFR bus and CPU move port are synchronous.
// How it works
// R1 - Pointer form uses full 16-bit data pointer
// R2 - Short form: page register high, R0/R1 low
// R3 - Page register resets zero, selects 256-byte page
// R4 - Data pointer readable/writable as two bytes
// R5 - Buffer enable maps USB RAM at 0x0400-0x07FF
// R6 - Window hides normal memory while enabled
// R7 - Software keeps USB clock at twice sysclk
// R8 - Buffer window access takes extra cycles
// R9 - Software avoids moves on USB packet data
// R10 - Pins claimed only during off-chip moves
// R11 - Input pins have drivers switched off
// R12 - Pin output mode never touched here
// R13 - Sharing bit: 0 shared pins, 1 separate
// R14 - Mode 00: everything goes on-chip
// R15 - Mode 01: split, short form upper undriven
// R16 - Software picks off-chip page in mode 01
// R17 - Mode 10: split, page register drives upper
// R18 - Mode 11: everything goes off-chip
// R19 - Strobe width field sets ALE 1-4 clocks
// R20 - Config bits 7 and 5 read zero
// R21 - Software skips strobe pins in crossbar
// R22 - Software parks pins high between accesses
// R23 - Internal mode wraps modulo on-chip size
// R24 - Shared pins: address under ALE, then data
// R25 - Mode 11 short form leaves upper undriven
// R26 - Off-chip access is timing plus four clocks
// R27 - On-chip size boundary is build parameter
// R28 - Buffer window beats memory mode steering
package emm_pkg;
  localparam logic [7:0] CFG_ADDR = 8'h85;
  localparam logic [7:0] PAGE_ADDR = 8'hAA;
  localparam logic [7:0] PTR_HI_ADDR = 8'h9A;
  localparam logic [7:0] PTR_LO_ADDR = 8'h9B;
  localparam logic [7:0] CFG_RESET = 8'h03;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] CFG_WMASK = 8'h5F;
  localparam int CFG_BUF_EN_BIT = 6;
  localparam int CFG_SHARE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_ALE_LSB = 0;
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
  localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;
  localparam logic [15:0] WIN_BASE = 16'h0400;
  localparam logic [15:0] WIN_LAST = 16'h07FF;
  localparam int BUF_AW = 10;
  localparam int FIXED_OVERHEAD = 4;
  localparam logic [4:0] LEAD_CYC = 5'h02;
  localparam logic [4:0] TAIL_CYC = 5'h02;
endpackage

// ---- core/emm_seq_if.sv ----
// Carries an off-chip access request to the strobe sequencer and its phases back.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface emm_seq_if;
  logic start;
  logic muxMode;
  logic [2:0] aleWidth;
  logic busy;
  logic addrPhase;
  logic aleHigh;
  logic strobeOn;
  logic capture;
  logic done;
  modport ctrl (output start, output muxMode, output aleWidth,
    input busy, input addrPhase, input aleHigh, input strobeOn, input capture, input done);
  modport seq (input start, input muxMode, input aleWidth,
    output busy, output addrPhase, output aleHigh, output strobeOn, output capture, output done);
endinterface

// ---- core/emm_bus_seq.sv ----
// Phase sequencer for one off-chip access: lead, ALE high/low, setup, strobe, hold, tail.
// Assumes start is only raised while idle.
`timescale 1ns/1ps
module emm_bus_seq #(
  parameter int SETUP = 0,
  parameter int STROBE = 1,
  parameter int HOLD = 0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  emm_seq_if.seq sq
);
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_ALEH, S_ALEL, S_SETUP, S_STRB, S_HOLD, S_TAIL} emm_seq_e;
  emm_seq_e st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  wire logic cntZero = (cnt_r == 5'h00);
  wire logic [4:0] aleCnt = {2'b00, sq.aleWidth} - 5'h01;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cntZero ? cnt_r : cnt_r - 5'h01;
    case (st_r)
      S_IDLE: if (sq.start) begin
        st_nxt = S_LEAD;
        cnt_nxt = emm_pkg::LEAD_CYC - 5'h01;
      end
      S_LEAD, S_ALEL: if (cntZero) begin
        if (st_r == S_LEAD && sq.muxMode) begin
          st_nxt = S_ALEH;
          cnt_nxt = aleCnt;
        end else if (SETUP > 0) begin
          st_nxt = S_SETUP;
          cnt_nxt = 5'(SETUP - 1);
        end else begin
          st_nxt = S_STRB;
          cnt_nxt = 5'(STROBE - 1);
        end
      end
      S_ALEH: if (cntZero) begin
        st_nxt = S_ALEL;
        cnt_nxt = aleCnt;
      end
      S_SETUP: if (cntZero) begin
        st_nxt = S_STRB;
        cnt_nxt = 5'(STROBE - 1);
      end
      S_STRB: if (cntZero) begin
        st_nxt = (HOLD > 0) ? S_HOLD : S_TAIL;
        cnt_nxt = (HOLD > 0) ? 5'(HOLD - 1) : emm_pkg::TAIL_CYC - 5'h01;
      end
      S_HOLD: if (cntZero) begin
        st_nxt = S_TAIL;
        cnt_nxt = emm_pkg::TAIL_CYC - 5'h01;
      end
      S_TAIL: if (cntZero) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      cnt_r <= 5'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sq.busy = (st_r != S_IDLE);
  assign sq.addrPhase = (st_r == S_LEAD) || (st_r == S_ALEH) || (st_r == S_ALEL);
  assign sq.aleHigh = (st_r == S_ALEH); // [R19]
  assign sq.strobeOn = (st_r == S_STRB);
  assign sq.capture = (st_r == S_STRB) && cntZero;
  assign sq.done = (st_r == S_TAIL) && cntZero;

  // ALE high phase lasts exactly the programmed width
  logic [2:0] aleRun_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) aleRun_r <= 3'h0;
    else aleRun_r <= (st_r == S_ALEH) ? aleRun_r + 3'h1 : 3'h0;
  end
  ale_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
    (st_r == S_ALEH && st_nxt == S_ALEL) |-> (aleRun_r + 3'h1 == sq.aleWidth))
    else $error("ALE high width differs from programmed field");
endmodule

// ---- core/emm_mapper.sv ----
// External data memory address mapper: address forming, mode steering, pins.
// Assumes CPU move and SFR ports synchronous to sys_clk; USB buffer answers bufAck.
`timescale 1ns/1ps
module emm_mapper #(
  parameter int RAM_BYTES = 4096,
  parameter int ADDR_SETUP = 0,
  parameter int STROBE_WIDTH = 1,
  parameter int ADDR_HOLD = 0,
  parameter int BUF_MIN_CYCLES = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWe,
  input wire logic sfrRe,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic ptrLoad,
  input wire logic [15:0] ptrLoadValue,
  input wire logic moveReq,
  input wire logic moveWrite,
  input wire logic moveShort,
  input wire logic [7:0] moveLowByte,
  input wire logic [7:0] moveWdata,
  output logic moveBusy,
  output logic moveDone,
  output logic [7:0] moveRdata,
  output logic bufReq,
  output logic bufWrite,
  output logic [9:0] bufAddr,
  output logic [7:0] bufWdata,
  input wire logic [7:0] bufRdata,
  input wire logic bufAck,
  output logic pinsClaimed,
  output logic [7:0] addrHiOut,
  output logic addrHiDrvN,
  output logic [7:0] addrLoOut,
  output logic addrLoDrvN,
  output logic [7:0] dataOut,
  input wire logic [7:0] dataIn,
  output logic dataDrvN,
  output logic aleOut,
  output logic rdStrobeN,
  output logic wrStrobeN,
  output logic ctrlDrvN
);
  localparam int RAM_AW = $clog2(RAM_BYTES);
  typedef enum logic [1:0] {M_IDLE, M_ONCHIP, M_BUFFER, M_OFFCHIP} emm_move_e;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] cfg_r;
  logic [7:0] page_r;
  logic [15:0] ptr_r;
  logic [7:0] sfrRdata_r;

  wire logic cfgWr = sfrWe && (sfrAddr == emm_pkg::CFG_ADDR);
  wire logic pageWr = sfrWe && (sfrAddr == emm_pkg::PAGE_ADDR);
  wire logic ptrHiWr = sfrWe && (sfrAddr == emm_pkg::PTR_HI_ADDR);
  wire logic ptrLoWr = sfrWe && (sfrAddr == emm_pkg::PTR_LO_ADDR);
  wire logic bufEnable = cfg_r[emm_pkg::CFG_BUF_EN_BIT];
  wire logic separatePins = cfg_r[emm_pkg::CFG_SHARE_BIT]; // [R13]
  wire logic [1:0] memMode = cfg_r[emm_pkg::CFG_MODE_LSB +: 2];
  wire logic [1:0] aleField = cfg_r[emm_pkg::CFG_ALE_LSB +: 2];

  logic [15:0] ptrNxt;
  always_comb begin
    ptrNxt = ptr_r;
    if (ptrLoad) begin
      ptrNxt = ptrLoadValue;
    end else begin
      if (ptrHiWr) ptrNxt[15:8] = sfrWdata; // [R4]
      if (ptrLoWr) ptrNxt[7:0] = sfrWdata; // [R4]
    end
  end

  logic [7:0] sfrReadMux;
  always_comb begin
    if (sfrAddr == emm_pkg::CFG_ADDR) sfrReadMux = cfg_r;
    else if (sfrAddr == emm_pkg::PAGE_ADDR) sfrReadMux = page_r;
    else if (sfrAddr == emm_pkg::PTR_HI_ADDR) sfrReadMux = ptr_r[15:8];
    else if (sfrAddr == emm_pkg::PTR_LO_ADDR) sfrReadMux = ptr_r[7:0];
    else sfrReadMux = 8'h00;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= emm_pkg::CFG_RESET;
      page_r <= emm_pkg::PAGE_RESET; // [R3]
      ptr_r <= emm_pkg::PTR_RESET;
      sfrRdata_r <= 8'h00;
    end else begin
      if (cfgWr) cfg_r <= sfrWdata & emm_pkg::CFG_WMASK; // [R20]
      if (pageWr) page_r <= sfrWdata;
      ptr_r <= ptrNxt;
      if (sfrRe) sfrRdata_r <= sfrReadMux;
    end
  end
  assign sfrRdata = sfrRdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Effective address and routing
  // Short form: page register supplies the 256-byte page
  wire logic [15:0] effAddr = moveShort ? {page_r, moveLowByte} : ptr_r; // [R1] [R2] [R3]
  wire logic inWindow = bufEnable && (effAddr >= emm_pkg::WIN_BASE) && (effAddr <= emm_pkg::WIN_LAST); // [R5]
  wire logic belowBoundary = ({1'b0, effAddr} < 17'(RAM_BYTES)); // [R27]
  logic routeOnChip;
  always_comb begin
    case (memMode)
      emm_pkg::MODE_INTERNAL: routeOnChip = 1'b1; // [R14]
      emm_pkg::MODE_SPLIT_NOBANK: routeOnChip = belowBoundary; // [R15]
      emm_pkg::MODE_SPLIT_BANK: routeOnChip = belowBoundary; // [R17]
      default: routeOnChip = 1'b0; // [R18]
    endcase
  end
  // Upper byte driven for pointer form, or short form in bank select mode
  wire logic hiDrive = !moveShort || (memMode == emm_pkg::MODE_SPLIT_BANK); // [R15] [R17] [R25]

  ////////////////////////////////////////////////////////////////////////////
  // Move sequencing
  emm_move_e st_r;
  emm_move_e stNxt;
  logic [15:0] accAddr_r;
  logic [7:0] accWdata_r;
  logic accWrite_r;
  logic hiDrive_r;
  logic mux_r;
  logic [7:0] rdata_r;
  logic done_r;
  logic [3:0] bufWait_r;
  logic [7:0] xram [RAM_BYTES];

  wire logic accept = moveReq && (st_r == M_IDLE);
  wire logic [RAM_AW-1:0] ramIdx = accAddr_r[RAM_AW-1:0]; // [R23]
  wire logic bufMinMet = (bufWait_r >= 4'(BUF_MIN_CYCLES));

  emm_seq_if sq ();
  assign sq.start = accept && !inWindow && !routeOnChip;
  assign sq.muxMode = !separatePins; // [R13]
  assign sq.aleWidth = {1'b0, aleField} + 3'h1; // [R19]

  emm_bus_seq #(
    .SETUP(ADDR_SETUP),
    .STROBE(STROBE_WIDTH),
    .HOLD(ADDR_HOLD)
  ) u_seq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sq(sq)
  );

  always_comb begin
    stNxt = st_r;
    case (st_r)
      M_IDLE: if (accept) begin
        if (inWindow) stNxt = M_BUFFER; // [R6] [R28]
        else if (routeOnChip) stNxt = M_ONCHIP;
        else stNxt = M_OFFCHIP;
      end
      M_ONCHIP: stNxt = M_IDLE;
      // Relies on the USB clock being fast enough to answer [R7]
      M_BUFFER: if (bufAck && bufMinMet) stNxt = M_IDLE; // [R8]
      M_OFFCHIP: if (sq.done) stNxt = M_IDLE; // [R26]
      default: stNxt = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= M_IDLE;
      accAddr_r <= 16'h0000;
      accWdata_r <= 8'h00;
      accWrite_r <= 1'b0;
      hiDrive_r <= 1'b0;
      mux_r <= 1'b0;
    end else begin
      st_r <= stNxt;
      if (accept) begin
        accAddr_r <= effAddr;
        accWdata_r <= moveWdata;
        accWrite_r <= moveWrite;
        hiDrive_r <= hiDrive;
        mux_r <= !separatePins;
      end
    end
  end

  // Buffer wait count; move ends only on ack with the minimum met
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) bufWait_r <= 4'h0;
    else if (st_r != M_BUFFER) bufWait_r <= 4'h0;
    else if (!bufMinMet) bufWait_r <= bufWait_r + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= (st_r != M_IDLE) && (stNxt == M_IDLE);
      if (st_r == M_ONCHIP && !accWrite_r) rdata_r <= xram[ramIdx];
      else if (st_r == M_BUFFER && bufAck && !accWrite_r) rdata_r <= bufRdata;
      else if (st_r == M_OFFCHIP && sq.capture && !accWrite_r) rdata_r <= dataIn;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (st_r == M_ONCHIP && accWrite_r) xram[ramIdx] <= accWdata_r;
  end

  assign moveBusy = (st_r != M_IDLE);
  assign moveDone = done_r;
  assign moveRdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // USB buffer port and external pins
  assign bufReq = (st_r == M_BUFFER);
  assign bufWrite = accWrite_r;
  assign bufAddr = accAddr_r[emm_pkg::BUF_AW-1:0];
  assign bufWdata = accWdata_r;

  wire logic offActive = (st_r == M_OFFCHIP);
  wire logic muxAddrPhase = mux_r && sq.addrPhase;
  // Pins released as soon as the move completes; output mode left to port logic [R12]
  assign pinsClaimed = offActive; // [R10]
  assign ctrlDrvN = !offActive; // [R10]
  assign addrHiOut = accAddr_r[15:8];
  assign addrHiDrvN = !(offActive && hiDrive_r); // [R10] [R25]
  assign addrLoOut = accAddr_r[7:0];
  assign addrLoDrvN = !(offActive && !mux_r); // [R13]
  // Shared pins: address first, data after the ALE low phase ends
  assign dataOut = muxAddrPhase ? accAddr_r[7:0] : accWdata_r; // [R24]
  assign dataDrvN = !(offActive && (muxAddrPhase || accWrite_r)); // [R11]
  assign aleOut = offActive && mux_r && sq.aleHigh; // [R19] [R24]
  assign rdStrobeN = !(offActive && sq.strobeOn && !accWrite_r);
  assign wrStrobeN = !(offActive && sq.strobeOn && accWrite_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic [6:0] offCnt_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) offCnt_r <= 7'h00;
    else offCnt_r <= offActive ? offCnt_r + 7'h01 : 7'h00;
  end
  wire logic [6:0] expectLen = 7'(emm_pkg::FIXED_OVERHEAD + ADDR_SETUP + STROBE_WIDTH + ADDR_HOLD)
    + (mux_r ? {3'b000, sq.aleWidth, 1'b0} : 7'h00);

  short_addr_a: assert property (accept && moveShort |=> accAddr_r == {$past(page_r), $past(moveLowByte)}) // [R2]
    else $error("Short form address not page and low byte");
  ptr_addr_a: assert property (accept && !moveShort |=> accAddr_r == $past(ptr_r)) // [R1]
    else $error("Pointer form address not data pointer");
  buf_window_a: assert property (accept && bufEnable && effAddr[15:10] == 6'h01 |=> st_r == M_BUFFER) // [R5]
    else $error("Window access not sent to USB buffer");
  mode_int_a: assert property (accept && memMode == emm_pkg::MODE_INTERNAL && !inWindow |=> // [R14]
    st_r == M_ONCHIP ##1 st_r == M_IDLE)
    else $error("Internal mode access left the chip");
  mode_ext_a: assert property (accept && memMode == emm_pkg::MODE_EXTERNAL && !inWindow |=> // [R18]
    pinsClaimed && !ctrlDrvN)
    else $error("External mode access stayed on chip");
  pins_idle_a: assert property (!offActive |-> ctrlDrvN && addrHiDrvN && addrLoDrvN && dataDrvN && !aleOut) // [R10]
    else $error("Pins driven outside an off-chip move");
  read_drv_a: assert property (offActive && !accWrite_r && !sq.addrPhase |-> dataDrvN) // [R11]
    else $error("Data drivers on during read phase");
  cfg_unused_a: assert property (sfrRe && sfrAddr == emm_pkg::CFG_ADDR |=> // [R20]
    sfrRdata[7] == 1'b0 && sfrRdata[5] == 1'b0)
    else $error("Unused config bits read nonzero");
  off_len_a: assert property (offActive && sq.done |-> offCnt_r + 7'h01 == expectLen) // [R26]
    else $error("Off-chip access length wrong");
  buf_slow_a: assert property ($rose(st_r == M_BUFFER) |=> st_r == M_BUFFER) // [R8]
    else $error("Buffer access finished as fast as on-chip");
  hi_undriven_a: assert property (accept && moveShort && memMode == emm_pkg::MODE_EXTERNAL |=> addrHiDrvN [*2]) // [R25]
    else $error("Upper address driven for short form in external mode");
  mux_addr_a: assert property (offActive && mux_r && sq.aleHigh |-> !dataDrvN && dataOut == accAddr_r[7:0]) // [R24]
    else $error("Shared pins not carrying low address under ALE");

  onchip_read_c: cover property (accept && !moveWrite ##1 st_r == M_ONCHIP ##1 moveDone);
  buf_access_c: cover property (st_r == M_BUFFER && bufAck && bufMinMet);
  mux_write_c: cover property (offActive && mux_r && accWrite_r && sq.done);
  sep_read_c: cover property (offActive && !mux_r && !accWrite_r && sq.capture);
endmodule

// ---- dv/emm_ext_partner.sv ----
// Off-chip SRAM behind the pins, with address latch, plus the USB buffer RAM.
// Assumes emm_mapper pin signals; port latches parked high between accesses.
`timescale 1ns/1ps
module emm_ext_partner (
  input wire logic sys_clk,
  input wire logic sepPins,
  input wire logic [3:0] bufDelay,
  input wire logic bufReq,
  input wire logic bufWrite,
  input wire logic [9:0] bufAddr,
  input wire logic [7:0] bufWdata,
  output logic [7:0] bufRdata,
  output logic bufAck,
  input wire logic [7:0] addrHiOut,
  input wire logic addrHiDrvN,
  input wire logic [7:0] addrLoOut,
  input wire logic [7:0] dataOut,
  input wire logic dataDrvN,
  input wire logic aleOut,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  output logic [7:0] dataIn
);
  logic [7:0] xmem [0:65535];
  logic [7:0] bmem [0:1023];
  logic [7:0] loLatch_r;
  logic [7:0] lastOut_r;
  logic [3:0] waitCnt_r;
  logic [15:0] pinAddr;
  ////////////////////////////////////////////////////////////////////////
  // Strobe pins taken as skipped by the crossbar
  // Undriven upper pins sit at the parked latch level
  assign pinAddr = {addrHiDrvN ? 8'hFF : addrHiOut, sepPins ? addrLoOut : loLatch_r};
  always_ff @(posedge sys_clk) begin
    if (aleOut) begin
      loLatch_r <= dataOut;
    end
    if (!wrStrobeN && !dataDrvN) begin
      xmem[pinAddr] <= dataOut;
    end
    if (!rdStrobeN) begin
      lastOut_r <= xmem[pinAddr];
    end
  end
  // Released data pins show the inverse of the last value
  assign dataIn = !rdStrobeN ? xmem[pinAddr] : ~lastOut_r;
  ////////////////////////////////////////////////////////////////////////
  // Buffer side answers after bufDelay cycles, USB clock at least twice sysclk
  always_ff @(posedge sys_clk) begin
    waitCnt_r <= bufReq ? waitCnt_r + 4'h1 : 4'h0;
    if (bufAck && bufWrite) begin
      bmem[bufAddr] <= bufWdata;
    end
  end
  assign bufAck = bufReq && (waitCnt_r >= bufDelay);
  assign bufRdata = bufAck ? bmem[bufAddr] : ~bmem[bufAddr];
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for emm_mapper against a reference map and SRAM partner.
// Assumes RAM_BYTES of 2048 and the default off-chip timing parameters.
`timescale 1ns/1ps
module testbench;
  localparam int RAM = 2048;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWe = 1'b0;
  logic sfrRe = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic ptrLoad = 1'b0;
  logic [15:0] ptrLoadValue = 16'h0000;
  logic moveReq = 1'b0;
  logic moveWrite = 1'b0;
  logic moveShort = 1'b0;
  logic [7:0] moveLowByte = 8'h00;
  logic [7:0] moveWdata = 8'h00;
  logic moveBusy, moveDone, bufReq, bufWrite, bufAck, pinsClaimed;
  logic [7:0] sfrRdata, moveRdata, bufWdata, bufRdata, addrHiOut, addrLoOut, dataOut, dataIn;
  logic [9:0] bufAddr;
  logic addrHiDrvN, addrLoDrvN, dataDrvN, aleOut, rdStrobeN, wrStrobeN, ctrlDrvN;
  logic sepPins = 1'b0;
  logic [3:0] bufDelay = 4'h0;
  logic [7:0] cfg = 8'h03;
  int mdl [int];
  int err_count = 0;
  int check_count = 0;

  always #2 sys_clk = ~sys_clk;

  emm_mapper #(.RAM_BYTES(RAM)) dut (.sys_clk, .rst_n, .sfrAddr, .sfrWe, .sfrRe, .sfrWdata, .sfrRdata,
    .ptrLoad, .ptrLoadValue, .moveReq, .moveWrite, .moveShort, .moveLowByte, .moveWdata, .moveBusy,
    .moveDone, .moveRdata, .bufReq, .bufWrite, .bufAddr, .bufWdata, .bufRdata, .bufAck, .pinsClaimed,
    .addrHiOut, .addrHiDrvN, .addrLoOut, .addrLoDrvN, .dataOut, .dataIn, .dataDrvN, .aleOut,
    .rdStrobeN, .wrStrobeN, .ctrlDrvN);
  emm_ext_partner partner (.sys_clk, .sepPins, .bufDelay, .bufReq, .bufWrite, .bufAddr, .bufWdata,
    .bufRdata, .bufAck, .addrHiOut, .addrHiDrvN, .addrLoOut, .dataOut, .dataDrvN, .aleOut,
    .rdStrobeN, .wrStrobeN, .dataIn);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkn(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWe <= 1'b1;
    @(posedge sys_clk);
    sfrWe <= 1'b0;
    if (a == emm_pkg::CFG_ADDR) begin
      cfg = d & 8'h5F;
      sepPins <= d[4];
    end
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRe <= 1'b1;
    @(posedge sys_clk);
    sfrRe <= 1'b0;
    @(negedge sys_clk);
    v = sfrRdata;
  endtask
  // One move with reference routing, timing and pin ownership checks
  task automatic xfer(input logic w, input logic sh, input logic [15:0] a, input logic [7:0] d);
    int n, claimed, ale, hiDrv, clash, kind, key, len, lo;
    logic [15:0] pins;
    if (sh) begin
      sfr_wr(emm_pkg::PAGE_ADDR, a[15:8]);
    end else begin
      @(posedge sys_clk);
      ptrLoad <= 1'b1;
      ptrLoadValue <= a;
      @(posedge sys_clk);
      ptrLoad <= 1'b0;
    end
    if (cfg[6] && a >= 16'h0400 && a <= 16'h07FF) kind = 1;
    else if (cfg[3:2] == 2'h0 || (cfg[3:2] != 2'h3 && a < RAM)) kind = 0;
    else kind = 2;
    pins = (sh && cfg[2]) ? {8'hFF, a[7:0]} : a;
    key = kind == 0 ? int'(a) % RAM : (kind == 1 ? int'(a) - 1024 + 65536 : int'(pins) + 131072);
    len = 5 + (cfg[4] ? 0 : 2 * (int'(cfg[1:0]) + 1));
    @(posedge sys_clk);
    moveReq <= 1'b1;
    moveWrite <= w;
    moveShort <= sh;
    moveLowByte <= a[7:0];
    moveWdata <= d;
    @(posedge sys_clk);
    moveReq <= 1'b0;
    n = 0;
    claimed = 0;
    ale = 0;
    hiDrv = 0;
    clash = 0;
    lo = 0;
    while (moveDone !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
      claimed += int'(pinsClaimed === 1'b1) + int'(ctrlDrvN === 1'b0);
      lo += int'(addrLoDrvN === 1'b0);
      ale += int'(aleOut === 1'b1);
      hiDrv += int'(addrHiDrvN === 1'b0);
      clash += int'(rdStrobeN === 1'b0 && dataDrvN !== 1'b1);
    end
    if (!w) chk8("read data", mdl.exists(key) ? 8'(mdl[key]) : 8'hxx, moveRdata);
    else mdl[key] = int'(d);
    chkn("input drive clash", 0, clash);
    chkn("lower driven", (kind == 2 && cfg[4]) ? len : 0, lo);
    if (kind == 2) begin
      chkn("offchip cycles", len + 1, n);
      chkn("claimed cycles", 2 * len, claimed);
      chkn("ale cycles", cfg[4] ? 0 : int'(cfg[1:0]) + 1, ale);
      chkn("upper driven", (sh && cfg[2]) ? 0 : 1, int'(hiDrv > 0));
    end else begin
      chkn("claimed cycles", 0, claimed);
      if (kind == 0) chkn("onchip cycles", 2, n);
      else chkn("buffer slower", 1, int'(n >= 4 && n < 60));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  initial begin
    logic [7:0] v, d;
    logic [15:0] a;
    logic [7:0] regA [5] = '{8'h85, 8'hAA, 8'h9A, 8'h9B, 8'hF0};
    logic [7:0] regE [5] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] win [4] = '{16'h0400, 16'h07FF, 16'h03FF, 16'h0800};
    void'($urandom(32'hd26b));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sfr_rd(regA[i], v);
      chk8("reset value", regE[i], v);
    end
    $display("test reset values done");
    sfr_wr(emm_pkg::CFG_ADDR, 8'hFF);
    sfr_rd(emm_pkg::CFG_ADDR, v);
    chk8("config unused bits", 8'h5F, v);
    d = 8'($urandom);
    sfr_wr(emm_pkg::PAGE_ADDR, d);
    sfr_rd(emm_pkg::PAGE_ADDR, v);
    chk8("page register", d, v);
    a = 16'($urandom);
    sfr_wr(8'h9A, a[15:8]);
    sfr_wr(8'h9B, a[7:0]);
    sfr_rd(8'h9A, v);
    chk8("pointer high", a[15:8], v);
    sfr_rd(8'h9B, v);
    chk8("pointer low", a[7:0], v);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        for (int f = 0; f < 4; f++) begin
          sfr_wr(emm_pkg::CFG_ADDR, {3'b000, 1'(s), 2'(m), 2'(f)});
          for (int k = 0; k < 3; k++) begin
            a = k == 0 ? 16'($urandom % 1024) : {1'b1, 15'($urandom)};
            d = 8'($urandom);
            xfer(1'b1, k == 2, a, d);
            xfer(1'b0, k == 2, a, 8'h00);
          end
        end
      end
    end
    $display("test mode sweep done");
    sfr_wr(emm_pkg::CFG_ADDR, 8'h00);
    xfer(1'b1, 1'b0, 16'h0123, 8'h3C);
    xfer(1'b0, 1'b0, 16'h0923, 8'h00);
    xfer(1'b0, 1'b1, 16'h1123, 8'h00);
    $display("test wrap done");
    sfr_wr(emm_pkg::CFG_ADDR, 8'h18);
    xfer(1'b1, 1'b0, 16'h0400, 8'h5A);
    for (int dl = 0; dl < 2; dl++) begin
      bufDelay <= dl == 0 ? 4'h0 : 4'h5;
      sfr_wr(emm_pkg::CFG_ADDR, 8'h58);
      for (int k = 0; k < 4; k++) begin
        d = 8'($urandom);
        xfer(1'b1, 1'(k), win[k], d);
        xfer(1'b0, 1'(k), win[k], 8'h00);
      end
    end
    sfr_wr(emm_pkg::CFG_ADDR, 8'h18);
    xfer(1'b0, 1'b0, 16'h0400, 8'h00);
    $display("test buffer window done");
    summarize();
  end
endmodule
